// >>> rtl/rotate_exec_pkg.sv
// Package: constants and carriers for the rotate execution block
package rotate_exec_pkg;
  // ----------------------------------------------------------------
  // Phases of one instruction cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

  // ----------------------------------------------------------------
  // Operations and field values
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    OP_ROTATE_LEFT_NO_CARRY = 1'b0,
    OP_ROTATE_RIGHT_CARRY   = 1'b1
  } rot_op_t;

  localparam logic DEST_ACCUM = 1'b0;
  localparam logic WIN_ACCESS = 1'b0;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    rot_op_t op;
    logic dest;
    logic window;
    logic [7:0] f_addr;
  } rot_instr_t;

  typedef struct packed {
    logic wr_en;
    logic [11:0] addr;
    logic [7:0] data;
  } mem_write_t;
endpackage

// >>> rtl/rotate_instruction_exec.sv
// Rotate instruction execution datapath, one instruction per four phases
// What this block does
// (RULE1) Left rotate moves operand one bit toward MSB, bit 7 wraps to bit 0
// (RULE2) Right rotate through carry: old carry enters bit 7, bit 0 becomes carry
// (RULE3) Destination flag 0 writes accumulator, 1 writes back to source location
// (RULE4) Window bit 0 resolves address inside the fixed access bank
// (RULE5) Window bit 1 takes upper address bits from the bank pointer
// (RULE6) Window 0, extended set, address up to 95: indexed literal offset addressing
// (RULE7) One word, one cycle: decode, read, process, write phases in order
module rotate_instruction_exec (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_instr_valid,
  input wire rotate_exec_pkg::rot_instr_t i_instr,
  input wire logic [3:0] i_bank_pointer,
  input wire logic i_ext_set_en,
  input wire logic [11:0] i_index_base,
  input wire logic [7:0] i_mem_rdata,
  output logic [11:0] o_mem_raddr,
  output logic o_mem_rd_en,
  output rotate_exec_pkg::mem_write_t o_mem_wr,
  output logic [7:0] o_accum,
  output logic o_carry,
  output logic [1:0] o_phase,
  output logic o_busy,
  output logic o_done
);
  import rotate_exec_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phase_t phase_ff;
  logic busy_ff;
  rot_instr_t instr_ff;
  logic [11:0] addr_ff;
  logic [7:0] operand_ff;
  logic [7:0] result_ff;
  logic res_carry_ff;
  logic [7:0] accum_ff;
  logic carry_ff;
  logic rd_en_ff;
  mem_write_t wr_ff;
  logic done_ff;

  // ----------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------
  wire logic use_access = (instr_ff.window == WIN_ACCESS); // [RULE4]
  wire logic use_indexed = use_access && i_ext_set_en && (instr_ff.f_addr <= INDEXED_LIMIT); // [RULE6]
  // Indexed offset wraps within the 12-bit space rather than faulting
  wire logic [11:0] indexed_addr = i_index_base + {4'h0, instr_ff.f_addr}; // [RULE6]
  wire logic [3:0] access_bank = (instr_ff.f_addr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK; // [RULE4]
  wire logic [11:0] access_addr = {access_bank, instr_ff.f_addr}; // [RULE4]
  wire logic [11:0] banked_addr = {i_bank_pointer, instr_ff.f_addr}; // [RULE5]
  wire logic [11:0] nxt_addr = use_indexed ? indexed_addr : (use_access ? access_addr : banked_addr);

  // ----------------------------------------------------------------
  // Rotate datapath
  // ----------------------------------------------------------------
  // Each result bit takes its neighbour, except bit 0 of the left rotate (old bit 7) and bit 7 of the right rotate (carry)
  wire logic is_right = (instr_ff.op == OP_ROTATE_RIGHT_CARRY);
  wire logic [7:0] rot_left;
  wire logic [7:0] rot_right;
  assign rot_left[0] = operand_ff[7]; // [RULE1]
  assign rot_right[7] = carry_ff; // [RULE2]
  for (genvar b = 0; b < 7; b++) begin : g_rot_bit
    assign rot_left[b + 1] = operand_ff[b]; // [RULE1]
    assign rot_right[b] = operand_ff[b + 1]; // [RULE2]
  end
  wire logic [7:0] nxt_result = is_right ? rot_right : rot_left;
  // Left rotate leaves the carry alone, so its next value is the current flag
  wire logic nxt_res_carry = is_right ? operand_ff[0] : carry_ff; // [RULE2]

  // ----------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------
  wire logic to_accum = (instr_ff.dest == DEST_ACCUM); // [RULE3]
  wire logic start = i_instr_valid && !busy_ff;
  wire logic in_decode = busy_ff && (phase_ff == PH_DECODE); // [RULE7]
  wire logic in_read = busy_ff && (phase_ff == PH_READ); // [RULE7]
  wire logic in_process = busy_ff && (phase_ff == PH_PROCESS); // [RULE7]
  wire logic in_write = busy_ff && (phase_ff == PH_WRITE); // [RULE7]

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // New instructions are taken only when idle, so a request during a cycle is ignored
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_ff <= PH_DECODE;
      busy_ff <= 1'b0;
    end else if (start) begin
      phase_ff <= PH_DECODE; // [RULE7]
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      unique case (phase_ff)
        PH_DECODE: phase_ff <= PH_READ; // [RULE7]
        PH_READ: phase_ff <= PH_PROCESS; // [RULE7]
        PH_PROCESS: phase_ff <= PH_WRITE; // [RULE7]
        PH_WRITE: begin
          phase_ff <= PH_DECODE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Instruction capture
  // ----------------------------------------------------------------
  // Fields are held for the whole cycle so the caller may drop them after the take
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      instr_ff <= '0;
    end else if (start) begin
      instr_ff <= i_instr; // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_ff <= ADDR_RESET;
    end else if (in_decode) begin
      addr_ff <= nxt_addr; // [RULE4] [RULE5] [RULE6]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_en_ff <= 1'b0;
    end else begin
      rd_en_ff <= in_decode; // [RULE7]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      operand_ff <= BYTE_RESET;
    end else if (in_read) begin
      operand_ff <= i_mem_rdata; // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // Process
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_ff <= BYTE_RESET;
    end else if (in_process) begin
      result_ff <= nxt_result; // [RULE1] [RULE2]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_carry_ff <= CARRY_RESET;
    end else if (in_process) begin
      res_carry_ff <= nxt_res_carry; // [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and carry
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      accum_ff <= ACCUM_RESET;
    end else if (in_write && to_accum) begin
      accum_ff <= result_ff; // [RULE3]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carry_ff <= CARRY_RESET;
    end else if (in_write) begin
      carry_ff <= res_carry_ff; // [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // Memory write-back
  // ----------------------------------------------------------------
  // Address and data follow every cycle; only the strobe marks a real write
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ff <= '0;
    end else begin
      wr_ff.wr_en <= in_write && !to_accum; // [RULE3]
      wr_ff.addr <= addr_ff;
      wr_ff.data <= result_ff;
    end
  end

  // ----------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= in_write; // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flip-flop, so no decode path reaches the pins
  assign o_mem_raddr = addr_ff;
  assign o_mem_rd_en = rd_en_ff;
  assign o_mem_wr = wr_ff;
  assign o_accum = accum_ff;
  assign o_carry = carry_ff;
  assign o_phase = phase_ff;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
endmodule

// >>> tb/rotate_exec_chk.sv
// Checker for rotate execution timing, addressing and results
module rotate_exec_chk import rotate_exec_pkg::*; (
  input wire logic i_ref_clk, i_rst_n, i_instr_valid, i_ext_set_en,
  input wire logic o_mem_rd_en, o_carry, o_busy, o_done,
  input wire rot_instr_t i_instr,
  input wire logic [3:0] i_bank_pointer,
  input wire logic [11:0] i_index_base, o_mem_raddr,
  input wire logic [7:0] i_mem_rdata, o_accum,
  input wire mem_write_t o_mem_wr,
  input wire logic [1:0] o_phase);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire tk = i_instr_valid && !o_busy;
  wire [7:0] f = i_instr.f_addr;
  wire idx = !i_instr.window && i_ext_set_en && f <= INDEXED_LIMIT;
  sequence s_phases;
    o_phase == 0 ##1 o_phase == 1 ##1 o_phase == 2 ##1 o_phase == 3;
  endsequence
  chk_phase_order: assert property (tk |=> s_phases) else $error("bad phase order");
  chk_done_delay: assert property (tk |-> ##4 !o_done ##1 o_done ##1 !o_done) else $error("done late");
  chk_read_pulse: assert property (tk |-> ##2 o_mem_rd_en ##1 !o_mem_rd_en) else $error("bad read");
  chk_left_rot: assert property (tk && !i_instr.op && !i_instr.dest |-> ##5
    o_accum == {$past(i_mem_rdata[6:0], 3), $past(i_mem_rdata[7], 3)}) else $error("bad left rotate");
  chk_right_carry: assert property (tk && i_instr.op |-> ##5 o_carry == $past(i_mem_rdata[0], 3))
    else $error("bad carry");
  chk_write_back: assert property (tk && i_instr.dest |-> ##5 o_mem_wr.wr_en &&
    o_mem_wr.addr == o_mem_raddr) else $error("no write back");
  chk_no_write: assert property (tk && !i_instr.dest |-> ##5 !o_mem_wr.wr_en) else $error("stray write");
  chk_bank_addr: assert property (tk && i_instr.window |-> ##2
    o_mem_raddr == {$past(i_bank_pointer), $past(f, 2)}) else $error("bad banked address");
  chk_index_addr: assert property (tk && idx |-> ##2 o_mem_raddr == $past(i_index_base) + $past(f, 2))
    else $error("bad indexed address");
  chk_access_addr: assert property (tk && !i_instr.window && !idx |-> ##2
    o_mem_raddr == {$past(f, 2) < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, $past(f, 2)})
    else $error("bad access");
endmodule

// >>> tb/rotate_instruction_exec_tb.sv
// Self-checking bench for the rotate execution block
module rotate_instruction_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rotate_exec_pkg::*;
  logic i_ref_clk = 0, i_rst_n = 0, i_instr_valid = 0, i_ext_set_en = 0;
  logic o_mem_rd_en, o_carry, o_busy, o_done, c_m;
  rot_instr_t i_instr = '0;
  logic [3:0] i_bank_pointer = '0;
  logic [11:0] i_index_base = '0, o_mem_raddr;
  logic [7:0] i_mem_rdata = '0, o_accum, lf = 8'h22, ex;
  logic [7:0] cf [4] = '{8'h5f, 8'h60, 8'h00, 8'hff};
  mem_write_t o_mem_wr;
  logic [1:0] o_phase;
  int miscompares, n_compared, cyc;
  always #12.5 i_ref_clk = ~i_ref_clk;
  rotate_instruction_exec i_rotate_instruction_exec (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .i_bank_pointer(i_bank_pointer),
    .i_ext_set_en(i_ext_set_en),
    .i_index_base(i_index_base),
    .i_mem_rdata(i_mem_rdata),
    .o_mem_raddr(o_mem_raddr),
    .o_mem_rd_en(o_mem_rd_en),
    .o_mem_wr(o_mem_wr),
    .o_accum(o_accum),
    .o_carry(o_carry),
    .o_phase(o_phase),
    .o_busy(o_busy),
    .o_done(o_done)
  );
  always @(posedge i_ref_clk) if (++cyc > 3000) begin
    miscompares++;
    finish_test();
  end
  function automatic logic [7:0] nx(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Returns the new carry above the rotated byte
  function automatic logic [8:0] rot_exp(logic op, logic [7:0] d, logic c);
    return op ? {d[0], c, d[7:1]} : {c, d[6:0], d[7]};
  endfunction
  function automatic logic [11:0] ea(rot_instr_t x);
    if (x.window) return {i_bank_pointer, x.f_addr};
    if (i_ext_set_en && x.f_addr <= 8'h5f) return i_index_base + x.f_addr;
    return {x.f_addr < 8'h60 ? 4'h0 : 4'hf, x.f_addr};
  endfunction
  task automatic cmp(logic [23:0] g, logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Valid is held one extra edge so a request during busy must be ignored
  task automatic run(rot_instr_t x);
    lf = nx(lf);
    i_mem_rdata = lf;
    i_bank_pointer = lf[3:0];
    i_index_base = {lf, lf[7:4]};
    i_instr = x;
    i_instr_valid = 1;
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_instr_valid = 0;
    repeat (2) @(posedge i_ref_clk);
    #1 cmp(o_done, 0);
    @(posedge i_ref_clk);
    #1 cmp(o_done, 1);
    cmp(o_mem_raddr, ea(x));
    {c_m, ex} = rot_exp(x.op, lf, c_m);
    cmp(o_carry, c_m);
    if (x.dest) cmp(o_mem_wr, {1'b1, ea(x), ex});
    else cmp({o_mem_wr.wr_en, o_accum}, {1'b0, ex});
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Corner addresses around the indexed limit come first, then random traffic
  initial begin
    repeat (12) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1;
    c_m = 0;
    cmp({o_busy, o_done, o_accum}, 0);
    for (int k = 0; k < 64; k++) begin
      lf = nx(lf);
      i_ext_set_en = lf[0] | (k < 8);
      run({lf[2], lf[3], lf[4] & (k > 3), k < 16 ? cf[k % 4] : nx(lf)});
    end
    finish_test();
  end
endmodule
bind rotate_instruction_exec rotate_exec_chk i_rotate_exec_chk (
  .i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n),
  .i_instr_valid(i_instr_valid),
  .i_ext_set_en(i_ext_set_en),
  .o_mem_rd_en(o_mem_rd_en),
  .o_carry(o_carry),
  .o_busy(o_busy),
  .o_done(o_done),
  .i_instr(i_instr),
  .i_bank_pointer(i_bank_pointer),
  .i_index_base(i_index_base),
  .o_mem_raddr(o_mem_raddr),
  .i_mem_rdata(i_mem_rdata),
  .o_accum(o_accum),
  .o_mem_wr(o_mem_wr),
  .o_phase(o_phase)
);
